/* asi_pkg.sv */
package asi_pkg;

    localparam logic [4:0] ASI_BAUD_BASE = 5'h10;
    localparam logic [4:0] ASI_PULSE_LEN = 5'h03;
    localparam logic [3:0] ASI_CHR7_BITS = 4'h7;
    localparam logic [3:0] ASI_CHR8_BITS = 4'h8;
    localparam logic [3:0] ASI_K_MAX = 4'hE;
    localparam logic [3:0] ASI_M_MAX = 4'h9;

    localparam logic [7:0] ASI_ERR_PARITY = 8'h04;
    localparam logic [7:0] ASI_ERR_FRAME = 8'h02;
    localparam logic [7:0] ASI_ERR_OVERRUN = 8'h01;
    localparam logic [7:0] ASI_ERR_NONE = 8'h00;

    localparam logic [1:0] ASI_PAR_NONE = 2'h0;
    localparam logic [1:0] ASI_PAR_ZERO = 2'h1;
    localparam logic [1:0] ASI_PAR_ODD = 2'h2;
    localparam logic [1:0] ASI_PAR_EVEN = 2'h3;

    typedef struct packed {
        logic transmit_enable_bit;
        logic receive_enable_bit;
        logic [1:0] parity;
        logic chr8;
        logic stop2;
        logic error_completion_mask_bit;
        logic infrared;
    } asi_mode_t;

    typedef struct packed {
        logic [3:0] prescale;
        logic [3:0] k;
    } asi_baud_t;

    typedef enum logic [4:0] {
        ASI_TX_IDLE = 5'h01,
        ASI_TX_START = 5'h02,
        ASI_TX_DATA = 5'h04,
        ASI_TX_PAR = 5'h08,
        ASI_TX_STOP = 5'h10
    } asi_tx_state_t;

    typedef enum logic [4:0] {
        ASI_RX_IDLE = 5'h01,
        ASI_RX_HALF = 5'h02,
        ASI_RX_DATA = 5'h04,
        ASI_RX_PAR = 5'h08,
        ASI_RX_STOP = 5'h10
    } asi_rx_state_t;

endpackage

/* asi_buf.sv */
module asi_buf
    import asi_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic [1:0] cnt;
    } asi_buf_st_t;

    asi_buf_st_t st;
    asi_buf_st_t next_st;
    logic push;
    logic pop;

    if (W < 1) begin : g_chk
        $error("asi_buf width must be at least one");
    end

    assign in_ready = (st.cnt != 2'h2);
    assign out_valid = (st.cnt != 2'h0);
    assign out_data = st.d0;

    always_comb begin
        push = in_valid && in_ready;
        pop = out_ready && out_valid;
        next_st = st;
        if (push && pop) begin
            if (st.cnt == 2'h1) begin
                next_st.d0 = in_data;
            end else begin
                next_st.d0 = st.d1;
                next_st.d1 = in_data;
            end
        end else if (pop) begin
            next_st.d0 = st.d1;
            next_st.cnt = st.cnt - 2'h1;
        end else if (push) begin
            if (st.cnt == 2'h0) begin
                next_st.d0 = in_data;
            end else begin
                next_st.d1 = in_data;
            end
            next_st.cnt = st.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

endmodule

/* asi_uart.sv */
// Function
// - Start, 7/8 data, parity option, 1/2 stops.
// - Seven-bit mode drops bit 7, reads zero.
// - Even parity: generate even, flag odd count.
// - Odd parity: generate odd, flag even count.
// - Zero parity sends zero, never checks.
// - No parity: no bit, no error.
// - Enabled write to shifter starts framed send.
// - Done interrupt when shifter empties.
// - Receive enable samples input at bit clock.
// - Falling edge, half bit recheck, then sample.
// - Reception ends after the first stop bit.
// - Frame goes to buffer, then done interrupt.
// - Error mask suppresses done interrupt on error.
// - Receive disable aborts frame; only RX_FULL still sets if its stop bit ends that cycle.
// - First instance raises error interrupt before done.
// - Status codes parity 04, frame 02, overrun 01.
// - Buffer read or new frame clears status.
// - Infrared only first instance, fixed 8N1.
// - Infrared pulse 3/(k+16) bit from mid-cell.
// - Infrared receive data lags half a bit.
// - Bit clock is clock/2^(m+1)/(k+16).
module asi_uart
    import asi_pkg::*;
#(
    parameter bit FIRST_INSTANCE = 1'b1
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire asi_mode_t MODE,
    input wire asi_baud_t BAUD,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic TX_BUSY,
    output logic TXD,
    input wire logic RXD,
    output logic [7:0] RX_DATA,
    output logic RX_FULL,
    input wire logic RX_READ,
    output logic [7:0] ERR_STATUS,
    output logic TX_DONE_IRQ,
    output logic RX_DONE_IRQ,
    output logic RX_ERR_IRQ
);

    typedef struct packed {
        logic [2:0] sync;
        logic rxl;
        logic lprev;
        logic [9:0] pre;
        logic [4:0] irc;
        asi_tx_state_t txs;
        logic [4:0] tcnt;
        logic [3:0] tbit;
        logic [7:0] tsh;
        logic tpar;
        logic txd;
        asi_rx_state_t rxs;
        logic [4:0] rcnt;
        logic [3:0] rbit;
        logic [7:0] rsh;
        logic rpar;
        logic [7:0] rbuf;
        logic full;
        logic [7:0] err;
        logic done_pend;
        logic tdone;
        logic rdone;
        logic rerr;
    } asi_st_t;

    asi_st_t st;
    asi_st_t next_st;

    logic buf_valid;
    logic buf_take;
    logic [7:0] buf_data;
    logic tick;
    logic ir;
    logic line;
    logic [4:0] blen;
    logic [4:0] half;
    logic [3:0] nbits;
    logic has_par;
    logic tbitv;
    logic t_end;
    logic r_end;
    logic pe;
    logic fe;
    logic [7:0] rdata;

    if (FIRST_INSTANCE !== 1'b0 && FIRST_INSTANCE !== 1'b1) begin : g_chk
        $error("asi_uart FIRST_INSTANCE must be 0 or 1");
    end

    function automatic logic [9:0] asi_pmask(input logic [3:0] m);
        logic [10:0] v;
        v = (11'h001 << (m + 4'h1)) - 11'h001;
        return v[9:0];
    endfunction

    function automatic logic [4:0] asi_blen(input logic [3:0] k);
        return {1'b0, k} + ASI_BAUD_BASE;
    endfunction

    function automatic logic asi_pulse(input logic [4:0] cnt,
                                       input logic [4:0] mid);
        return (cnt >= mid) && (cnt < mid + ASI_PULSE_LEN);
    endfunction

    function automatic logic asi_tx_parity(input logic [1:0] p,
                                           input logic [7:0] d);
        logic v;
        v = 1'b0;
        if (p == ASI_PAR_EVEN) begin
            v = ^d;
        end else if (p == ASI_PAR_ODD) begin
            v = ~^d;
        end
        return v;
    endfunction

    asi_buf #(
        .W(8)
    ) u_txbuf (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .in_data(TX_DATA),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data(buf_data)
    );

    assign TX_BUSY = (st.txs != ASI_TX_IDLE);
    assign TXD = st.txd;
    assign RX_DATA = st.rbuf;
    assign RX_FULL = st.full;
    assign ERR_STATUS = st.err;
    assign TX_DONE_IRQ = st.tdone;
    assign RX_DONE_IRQ = st.rdone;
    assign RX_ERR_IRQ = st.rerr;

    always_comb begin
        next_st = st;
        ir = MODE.infrared && FIRST_INSTANCE;
        tick = ((st.pre & asi_pmask(BAUD.prescale)) ==
                asi_pmask(BAUD.prescale));
        blen = asi_blen(BAUD.k);
        half = blen >> 1;
        nbits = (MODE.chr8 || ir) ? ASI_CHR8_BITS : ASI_CHR7_BITS;
        has_par = (MODE.parity != ASI_PAR_NONE) && !ir;
        line = ir ? (st.irc == 5'h00) : st.rxl;
        t_end = tick && (st.tcnt == blen - 5'h01);
        r_end = tick && (st.rcnt == blen - 5'h01);
        buf_take = 1'b0;
        tbitv = 1'b1;
        pe = 1'b0;
        fe = 1'b0;
        rdata = MODE.chr8 || ir ? st.rsh : {1'b0, st.rsh[7:1]};
        next_st.tdone = 1'b0;
        next_st.rdone = 1'b0;
        next_st.rerr = 1'b0;

        next_st.pre = st.pre + 10'h001;
        next_st.sync = {st.sync[1:0], RXD};
        if (st.sync[1] == st.sync[2]) begin
            next_st.rxl = st.sync[2];
        end
        next_st.lprev = line;

        if (ir && st.rxl && (st.sync[1] == st.sync[2]) && !st.sync[2]) begin
            next_st.irc = st.irc;
        end
        if (ir && !st.rxl && st.sync[2] && (st.sync[1] == st.sync[2])) begin
            next_st.irc = blen;
        end else if (tick && st.irc != 5'h00) begin
            next_st.irc = st.irc - 5'h01;
        end

        if (tick && st.txs != ASI_TX_IDLE) begin
            next_st.tcnt = t_end ? 5'h00 : st.tcnt + 5'h01;
        end
        case (st.txs)
            ASI_TX_IDLE: begin
                tbitv = 1'b1;
                if (MODE.transmit_enable_bit && buf_valid) begin
                    buf_take = 1'b1;
                    next_st.tsh = MODE.chr8 || ir ? buf_data
                                  : {1'b0, buf_data[6:0]};
                    next_st.tpar = asi_tx_parity(MODE.parity,
                                                 next_st.tsh);
                    next_st.tcnt = 5'h00;
                    next_st.tbit = 4'h0;
                    next_st.txs = ASI_TX_START;
                end
            end
            ASI_TX_START: begin
                tbitv = 1'b0;
                if (t_end) begin
                    next_st.txs = ASI_TX_DATA;
                end
            end
            ASI_TX_DATA: begin
                tbitv = st.tsh[0];
                if (t_end) begin
                    next_st.tsh = {1'b0, st.tsh[7:1]};
                    next_st.tbit = st.tbit + 4'h1;
                    if (st.tbit == nbits - 4'h1) begin
                        next_st.tbit = 4'h0;
                        next_st.txs = has_par ? ASI_TX_PAR
                                      : ASI_TX_STOP;
                    end
                end
            end
            ASI_TX_PAR: begin
                tbitv = st.tpar;
                if (t_end) begin
                    next_st.txs = ASI_TX_STOP;
                end
            end
            ASI_TX_STOP: begin
                tbitv = 1'b1;
                if (t_end) begin
                    next_st.tbit = st.tbit + 4'h1;
                    if (st.tbit != 4'h0 || !MODE.stop2 || ir) begin
                        next_st.txs = ASI_TX_IDLE;
                        next_st.tdone = 1'b1;
                    end
                end
            end
            default: begin
                next_st.txs = ASI_TX_IDLE;
            end
        endcase
        if (ir) begin
            next_st.txd = (st.txs != ASI_TX_IDLE) && !tbitv &&
                          asi_pulse(st.tcnt, half);
        end else begin
            next_st.txd = tbitv;
        end

        if (RX_READ) begin
            next_st.full = 1'b0;
            next_st.err = ASI_ERR_NONE;
        end
        if (st.done_pend) begin
            next_st.done_pend = 1'b0;
            next_st.rdone = 1'b1;
        end

        if (tick && st.rxs != ASI_RX_IDLE) begin
            next_st.rcnt = st.rcnt + 5'h01;
        end
        case (st.rxs)
            ASI_RX_IDLE: begin
                if (MODE.receive_enable_bit && st.lprev && !line) begin
                    next_st.rcnt = 5'h00;
                    next_st.rxs = ASI_RX_HALF;
                end
            end
            ASI_RX_HALF: begin
                if (tick && st.rcnt == half - 5'h01) begin
                    next_st.rcnt = 5'h00;
                    next_st.rbit = 4'h0;
                    next_st.rpar = 1'b0;
                    next_st.rxs = line ? ASI_RX_IDLE : ASI_RX_DATA;
                end
            end
            ASI_RX_DATA: begin
                if (r_end) begin
                    next_st.rcnt = 5'h00;
                    next_st.rsh = {line, st.rsh[7:1]};
                    next_st.rpar = st.rpar ^ line;
                    next_st.rbit = st.rbit + 4'h1;
                    if (st.rbit == nbits - 4'h1) begin
                        next_st.rxs = has_par ? ASI_RX_PAR
                                      : ASI_RX_STOP;
                    end
                end
            end
            ASI_RX_PAR: begin
                if (r_end) begin
                    next_st.rcnt = 5'h00;
                    next_st.rpar = st.rpar ^ line;
                    next_st.rxs = ASI_RX_STOP;
                end
            end
            ASI_RX_STOP: begin
                if (r_end) begin
                    if (MODE.parity == ASI_PAR_EVEN && !ir) begin
                        pe = st.rpar;
                    end else if (MODE.parity == ASI_PAR_ODD && !ir) begin
                        pe = !st.rpar;
                    end
                    fe = !line;
                    next_st.rbuf = rdata;
                    next_st.err = (pe ? ASI_ERR_PARITY : ASI_ERR_NONE) |
                                  (fe ? ASI_ERR_FRAME : ASI_ERR_NONE) |
                                  (st.full ? ASI_ERR_OVERRUN
                                   : ASI_ERR_NONE);
                    next_st.full = 1'b1;
                    next_st.rerr = FIRST_INSTANCE &&
                                   (next_st.err != ASI_ERR_NONE);
                    next_st.done_pend = (next_st.err == ASI_ERR_NONE) ||
                        !MODE.error_completion_mask_bit;
                    next_st.rxs = ASI_RX_IDLE;
                end
            end
            default: begin
                next_st.rxs = ASI_RX_IDLE;
            end
        endcase
        if (!MODE.receive_enable_bit && st.rxs != ASI_RX_IDLE) begin
            next_st.rxs = ASI_RX_IDLE;
            next_st.rbuf = st.rbuf;
            next_st.err = RX_READ ? ASI_ERR_NONE : st.err;
            next_st.rerr = 1'b0;
            next_st.done_pend = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st <= '0;
            st.sync <= 3'h7;
            st.rxl <= 1'b1;
            st.lprev <= 1'b1;
            st.txd <= 1'b1;
            st.txs <= ASI_TX_IDLE;
            st.rxs <= ASI_RX_IDLE;
        end else if (CE) begin
            st <= next_st;
        end
    end

endmodule

/* asi_uart_monitor.sv */
module asi_mon
    import asi_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire asi_mode_t MODE,
    input wire logic TX_BUSY,
    input wire logic TXD,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_FULL,
    input wire logic RX_READ,
    input wire logic [7:0] ERR_STATUS,
    input wire logic TX_DONE_IRQ,
    input wire logic RX_DONE_IRQ,
    input wire logic RX_ERR_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_err;
        RX_ERR_IRQ && !MODE.error_completion_mask_bit;
    endsequence
    property p_idle;
        !TX_BUSY && $stable(MODE) && !MODE.infrared |-> TXD;
    endproperty
    a_idle: assert property (p_idle) else $error("line not idle high");
    property p_start;
        $rose(TX_BUSY) && !MODE.infrared |=> !TXD [*3];
    endproperty
    a_start: assert property (p_start) else $error("no low start bit");
    property p_done;
        $fell(TX_BUSY) |-> TX_DONE_IRQ;
    endproperty
    a_done: assert property (p_done) else $error("no transmit done pulse");
    property p_err_done;
        s_err |=> RX_DONE_IRQ;
    endproperty
    a_err_done: assert property (p_err_done) else $error("done not after error");
    property p_mask;
        RX_ERR_IRQ && MODE.error_completion_mask_bit |=> !RX_DONE_IRQ;
    endproperty
    a_mask: assert property (p_mask) else $error("masked done pulse seen");
    property p_err_stat;
        RX_ERR_IRQ |-> RX_FULL && ERR_STATUS != 8'h00;
    endproperty
    a_err_stat: assert property (p_err_stat) else $error("error pulse, no status");
    property p_read_clr;
        RX_READ |=> ERR_STATUS == 8'h00 || RX_ERR_IRQ;
    endproperty
    a_read_clr: assert property (p_read_clr) else $error("status kept on read");
    property p_abort;
        !MODE.receive_enable_bit [*3] |-> !RX_DONE_IRQ && $stable(RX_DATA);
    endproperty
    a_abort: assert property (p_abort) else $error("receive while disabled");
endmodule

bind asi_uart asi_mon mon (
    .CLK(CLK), .RSTN(RSTN), .MODE(MODE), .TX_BUSY(TX_BUSY), .TXD(TXD),
    .RX_DATA(RX_DATA), .RX_FULL(RX_FULL), .RX_READ(RX_READ),
    .ERR_STATUS(ERR_STATUS), .TX_DONE_IRQ(TX_DONE_IRQ),
    .RX_DONE_IRQ(RX_DONE_IRQ), .RX_ERR_IRQ(RX_ERR_IRQ)
);

/* asi_peer.sv */
module asi_peer
    import asi_pkg::*;
#(
    parameter int BIT = 64
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] q[$];
    logic [11:0] f;
    logic on = 1'h1;
    logic prev = 1'h1;
    int ncap = 10;
    initial rxd = 1'h1;
    task automatic send(input logic [11:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= b[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'h1;
    endtask
    initial forever begin
        @(posedge clk);
        if (on && prev && !txd) begin
            repeat (BIT / 2) @(posedge clk);
            f = 12'hFFF;
            for (int i = 0; i < ncap; i++) begin
                if (i > 0) repeat (BIT) @(posedge clk);
                f[i] = txd;
            end
            q.push_back(f);
        end
        prev = txd;
    end
endmodule

/* tb.sv */
module tb
    import asi_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rstn, tx_valid, tx_ready, tx_busy, txd, rxd, rx_full;
    logic rx_read, tx_done, rx_done, rx_err;
    logic [7:0] tx_data, rx_data, err;
    asi_mode_t mode;
    int miscompares = 0, compares = 0, cyc = 0, hi;
    int ndone = 0, nerr = 0;
    asi_uart dut (
        .CLK(clk), .RSTN(rstn), .CE(1'h1), .MODE(mode),
        .BAUD(asi_baud_t'(8'h10)), .TX_DATA(tx_data),
        .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_BUSY(tx_busy),
        .TXD(txd), .RXD(rxd), .RX_DATA(rx_data), .RX_FULL(rx_full),
        .RX_READ(rx_read), .ERR_STATUS(err), .TX_DONE_IRQ(tx_done),
        .RX_DONE_IRQ(rx_done), .RX_ERR_IRQ(rx_err)
    );
    asi_peer #(.BIT(64)) peer (.clk(clk), .txd(txd), .rxd(rxd));
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        ndone += int'(rx_done);
        nerr += int'(rx_err);
        if (cyc == 40000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input logic [19:0] s, e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic int flen;
        return (mode.chr8 ? 10 : 9) + int'(mode.parity != ASI_PAR_NONE)
            + int'(mode.stop2);
    endfunction
    function automatic logic [11:0] frame(input logic [7:0] d);
        logic [11:0] f;
        int n;
        f = 12'hFFE;
        n = mode.chr8 ? 8 : 7;
        d[7] = d[7] & mode.chr8;
        for (int i = 0; i < n; i++)
            f[i + 1] = d[i];
        case (mode.parity)
            ASI_PAR_ZERO: f[n + 1] = 1'h0;
            ASI_PAR_ODD: f[n + 1] = ~^d;
            ASI_PAR_EVEN: f[n + 1] = ^d;
            default: ;
        endcase
        return f;
    endfunction
    task automatic cfg(input logic [1:0] p, input logic c8, s2, ir, msk);
        @(posedge clk);
        mode <= '{1'h1, 1'h1, p, c8, s2, msk, ir};
        @(posedge clk);
        peer.ncap = flen();
    endtask
    task automatic tx(input logic [7:0] d);
        @(posedge clk);
        tx_valid <= 1'h1;
        tx_data <= d;
        do
            @(posedge clk);
        while (!tx_ready);
        tx_valid <= 1'h0;
    endtask
    task automatic wait_tx;
        int i = 0;
        hi = 0;
        do begin
            @(posedge clk);
            hi += int'(txd);
            i++;
        end while (tx_done !== 1'h1 && i < 4000);
        chk(tx_done, 1'h1);
    endtask
    task automatic rx(input logic [11:0] f, input logic [7:0] d, e,
                      input bit rd);
        int d0;
        int e0;
        @(posedge clk);
        d0 = ndone;
        e0 = nerr;
        peer.send(f, flen());
        chk({rx_full, rx_data}, {1'h1, d});
        chk(err, e);
        chk(ndone - d0, (e == 8'h00 || !mode.error_completion_mask_bit));
        chk(nerr - e0, (e != 8'h00));
        if (rd) begin
            rx_read <= 1'h1;
            @(posedge clk);
            rx_read <= 1'h0;
            @(posedge clk);
            chk({rx_full, err}, 9'h000);
        end
    endtask
    initial begin
        rstn = 1'h0;
        mode = '0;
        tx_valid = 1'h0;
        tx_data = 8'h00;
        rx_read = 1'h0;
        repeat (5) @(posedge clk);
        chk({txd, tx_ready, tx_busy, rx_full, err, rx_data}, 20'hC0000);
        rstn <= 1'h1;
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            cfg(c[1:0], c[0], c[1], 1'h0, 1'h0);
            tx(8'hA7);
            tx(8'h5C);
            wait_tx();
            wait_tx();
            chk(peer.q.size(), 20'h00002);
            chk(peer.q.pop_front(), frame(8'hA7));
            chk(peer.q.pop_front(), frame(8'h5C));
        end
        $display("transmit test done");
        peer.on = 1'h0;
        cfg(ASI_PAR_NONE, 1'h1, 1'h0, 1'h1, 1'h0);
        tx(8'h5A);
        wait_tx();
        chk(hi, 5 * 64 * 3 / 16);
        cfg(ASI_PAR_EVEN, 1'h1, 1'h0, 1'h0, 1'h0);
        peer.on = 1'h1;
        $display("infrared test done");
        rx(frame(8'h96), 8'h96, 8'h00, 1);
        rx(frame(8'h96) ^ 12'h200, 8'h96, ASI_ERR_PARITY, 1);
        cfg(ASI_PAR_ODD, 1'h1, 1'h0, 1'h0, 1'h1);
        rx(frame(8'h96) ^ 12'h200, 8'h96, ASI_ERR_PARITY, 1);
        rx(frame(8'h96), 8'h96, 8'h00, 1);
        cfg(ASI_PAR_ZERO, 1'h0, 1'h0, 1'h0, 1'h0);
        rx(frame(8'hF1) ^ 12'h100, 8'h71, 8'h00, 1);
        cfg(ASI_PAR_NONE, 1'h1, 1'h0, 1'h0, 1'h0);
        rx(frame(8'h3C) ^ 12'h200, 8'h3C, ASI_ERR_FRAME, 1);
        rx(frame(8'h11), 8'h11, 8'h00, 0);
        rx(frame(8'h22), 8'h22, ASI_ERR_OVERRUN, 1);
        peer.rxd <= 1'h0;
        repeat (20) @(posedge clk);
        peer.rxd <= 1'h1;
        repeat (700) @(posedge clk);
        chk(rx_full, 1'h0);
        hi = ndone;
        fork
            peer.send(frame(8'h55), 10);
            begin
                repeat (300) @(posedge clk);
                mode.receive_enable_bit <= 1'h0;
            end
        join
        chk({rx_full, err, rx_data}, 17'h00022);
        chk(ndone - hi, 20'h00000);
        mode.receive_enable_bit <= 1'h1;
        rx(frame(8'hC3), 8'hC3, 8'h00, 1);
        $display("receive test done");
        close_out();
    end
endmodule
